/* design/perf_event_counter.sv */
// Performance event selection and counting for one core
//
// Contract
// - Event 3CH mask 00H counts each core cycle while the core is not halted.
// - Event 3CH mask 01H counts each bus cycle while the core is not halted.
// - Mask 02H counts bus cycles with this core running and other core halted.
// - Event 40H mask 21H counts every cacheable data read.
// - Event 40H mask 22H counts every cacheable data write.
// - Event 60H adds outstanding full-line bus reads every cycle.
// - A line read is outstanding from issue cycle through full-line receipt cycle; the code tracks at most 15 pending and drops reads issued past that.
// - Outstanding-read count ignores logical processor and the any-thread qualifier.
// - Programmable counter counts unhalted cycles; a fixed counter always counts them.
`timescale 1ns/10ps
module perf_event_counter
    import perf_event_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire evtSel_t evtSel,
    input wire coreEvt_t coreEvt,
    input wire logic anyThread,
    output logic [CNT_W-1:0] progCount,
    output logic [CNT_W-1:0] fixedCount,
    output logic [PEND_W-1:0] pendReads
);

    perfState_t state;
    perfState_t next_state;
    evtSrc_t src;
    logic [PEND_W:0] outstNow;
    logic progInc;
    logic [CNT_W-1:0] progStep;

    // Selection decode
    // pair match
    always_comb
    begin
        src = SRC_NONE;
        case (evtSel.eventNum)
            EVT_UNHALTED:
            begin
                case (evtSel.unitMask)
                    UM_CORE: src = SRC_CORE;
                    UM_BUS: src = SRC_BUS;
                    UM_NO_OTHER: src = SRC_NO_OTHER;
                    default: src = SRC_NONE;
                endcase
            end
            EVT_L1D:
            begin
                case (evtSel.unitMask)
                    UM_LD: src = SRC_LD;
                    UM_ST: src = SRC_ST;
                    default: src = SRC_NONE;
                endcase
            end
            // Any mask accepted: the core-or-both split has no meaning here
            EVT_BUS_OUTST: src = SRC_OUTST;
            default: src = SRC_NONE;
        endcase
    end

    // issue cycle counts
    // A read issued this cycle already counts; the done cycle still counts too.
    assign outstNow = {1'b0, state.pendReads} + {{PEND_W{1'b0}}, coreEvt.lineReadIssue};

    always_comb
    begin
        progInc = 1'b0;
        progStep = CNT_ONE;
        case (src)
            SRC_CORE: progInc = !coreEvt.coreHalted;
            SRC_BUS: progInc = coreEvt.busTick && !coreEvt.coreHalted;
            SRC_NO_OTHER: progInc = coreEvt.busTick && !coreEvt.coreHalted &&
                                    coreEvt.otherHalted;
            SRC_LD: progInc = coreEvt.dataRead;
            SRC_ST: progInc = coreEvt.dataWrite;
            SRC_OUTST:
            begin
                progInc = 1'b1;
                progStep = CNT_W'(outstNow);
            end
            default: progInc = 1'b0;
        endcase
    end

    always_comb
    begin
        next_state = state;
        if (progInc)
        begin
            next_state.progCount = state.progCount + progStep;
        end
        if (!coreEvt.coreHalted)
        begin
            next_state.fixedCount = state.fixedCount + CNT_ONE;
        end
        // pending tracker
        // Saturates rather than wraps; a stray done with nothing pending is dropped.
        if (coreEvt.lineReadIssue && !coreEvt.lineReadDone && state.pendReads != PEND_MAX)
        begin
            next_state.pendReads = state.pendReads + PEND_ONE;
        end
        else if (!coreEvt.lineReadIssue && coreEvt.lineReadDone &&
                 state.pendReads != PEND_RESET)
        begin
            next_state.pendReads = state.pendReads - PEND_ONE;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state.progCount <= CNT_RESET;
            state.fixedCount <= CNT_RESET;
            state.pendReads <= PEND_RESET;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign progCount = state.progCount;
    assign fixedCount = state.fixedCount;
    assign pendReads = state.pendReads;

    sequence seqUnhaltedCore;
        src == SRC_CORE && !coreEvt.coreHalted;
    endsequence

    sequence seqBusRunning;
        src == SRC_BUS && coreEvt.busTick && !coreEvt.coreHalted;
    endsequence

    sequence seqOnlyThisCore;
        src == SRC_NO_OTHER && coreEvt.busTick && !coreEvt.coreHalted && coreEvt.otherHalted;
    endsequence

    sequence seqLineDone;
        coreEvt.lineReadDone && !coreEvt.lineReadIssue && pendReads != PEND_RESET;
    endsequence

    AST_CORE_UNHALTED: assert property (@(posedge clk) disable iff (!nrst)
        seqUnhaltedCore |=> progCount == $past(progCount) + CNT_ONE)
        else $error("core cycle not counted");

    AST_CORE_HALTED: assert property (@(posedge clk) disable iff (!nrst)
        (src == SRC_CORE && coreEvt.coreHalted) |=> $stable(progCount))
        else $error("core cycle counted while halted");

    AST_BUS_UNHALTED: assert property (@(posedge clk) disable iff (!nrst)
        seqBusRunning |=> progCount == $past(progCount) + CNT_ONE)
        else $error("bus cycle not counted");

    AST_ONLY_THIS_CORE: assert property (@(posedge clk) disable iff (!nrst)
        (src == SRC_NO_OTHER && !coreEvt.otherHalted) |=> $stable(progCount))
        else $error("counted while other core running");

    AST_ONLY_THIS_CORE_INC: assert property (@(posedge clk) disable iff (!nrst)
        seqOnlyThisCore |=> progCount == $past(progCount) + CNT_ONE)
        else $error("single core bus cycle not counted");

    AST_DATA_READ: assert property (@(posedge clk) disable iff (!nrst)
        (src == SRC_LD) |=> progCount == $past(progCount) + CNT_W'($past(coreEvt.dataRead)))
        else $error("cacheable read count wrong");

    AST_DATA_WRITE: assert property (@(posedge clk) disable iff (!nrst)
        (src == SRC_ST) |=> progCount == $past(progCount) + CNT_W'($past(coreEvt.dataWrite)))
        else $error("cacheable write count wrong");

    AST_OUTST_ADD: assert property (@(posedge clk) disable iff (!nrst)
        (src == SRC_OUTST) |=> progCount == $past(progCount) + CNT_W'($past(outstNow)))
        else $error("outstanding reads not added");

    AST_PEND_ISSUE: assert property (@(posedge clk) disable iff (!nrst)
        (coreEvt.lineReadIssue && !coreEvt.lineReadDone && pendReads < PEND_MAX)
        |=> pendReads == $past(pendReads) + PEND_ONE)
        else $error("issued read not pending");

    AST_FIXED_COUNT: assert property (@(posedge clk) disable iff (!nrst)
        !coreEvt.coreHalted |=> fixedCount == $past(fixedCount) + CNT_ONE)
        else $error("fixed counter missed unhalted cycle");

    AST_UNKNOWN_SEL: assert property (@(posedge clk) disable iff (!nrst)
        (src == SRC_NONE) |=> $stable(progCount))
        else $error("unknown selection incremented");

    AST_BUS_NO_TICK: assert property (@(posedge clk) disable iff (!nrst)
        (src == SRC_BUS && !coreEvt.busTick) |=> $stable(progCount))
        else $error("bus cycle counted without tick");

    AST_PEND_DONE: assert property (@(posedge clk) disable iff (!nrst)
        seqLineDone
        |=> pendReads == $past(pendReads) - PEND_ONE)
        else $error("received line still pending");

    AST_PEND_BOTH: assert property (@(posedge clk) disable iff (!nrst)
        (coreEvt.lineReadIssue && coreEvt.lineReadDone) |=> $stable(pendReads))
        else $error("pending count moved on issue with done");

    // qualifier ignored
    // The qualifier must not split or gate the sum, so the set case is checked alone
    AST_OUTST_THREAD: assert property (@(posedge clk) disable iff (!nrst)
        (src == SRC_OUTST && anyThread) |=> progCount == $past(progCount) + CNT_W'($past(outstNow)))
        else $error("outstanding sum changed by qualifier");

endmodule // perf_event_counter

/* design/perf_event_pkg.sv */
// Constants and carrier types for the performance event counter block
package perf_event_pkg;

    localparam int CNT_W = 40;
    localparam int PEND_W = 4;

    localparam logic [7:0] EVT_UNHALTED = 8'h3c;
    localparam logic [7:0] UM_CORE = 8'h00;
    localparam logic [7:0] UM_BUS = 8'h01;
    localparam logic [7:0] UM_NO_OTHER = 8'h02;
    localparam logic [7:0] EVT_L1D = 8'h40;
    localparam logic [7:0] UM_LD = 8'h21;
    localparam logic [7:0] UM_ST = 8'h22;
    localparam logic [7:0] EVT_BUS_OUTST = 8'h60;

    localparam logic [CNT_W-1:0] CNT_RESET = 40'h00_0000_0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 40'h00_0000_0001;
    localparam logic [PEND_W-1:0] PEND_RESET = 4'h0;
    localparam logic [PEND_W-1:0] PEND_ONE = 4'h1;
    localparam logic [PEND_W-1:0] PEND_MAX = 4'hf;

    // Decoded counted condition
    typedef enum logic [2:0]
    {
        SRC_NONE = 3'h0,
        SRC_CORE = 3'h1,
        SRC_BUS = 3'h3,
        SRC_NO_OTHER = 3'h2,
        SRC_LD = 3'h6,
        SRC_ST = 3'h7,
        SRC_OUTST = 3'h5
    } evtSrc_t;

    typedef struct packed {
        logic [7:0] eventNum;
        logic [7:0] unitMask;
    } evtSel_t;

    typedef struct packed {
        logic coreHalted;
        logic otherHalted;
        logic busTick;
        logic dataRead;
        logic dataWrite;
        logic lineReadIssue;
        logic lineReadDone;
    } coreEvt_t;

    typedef struct packed {
        logic [CNT_W-1:0] progCount;
        logic [CNT_W-1:0] fixedCount;
        logic [PEND_W-1:0] pendReads;
    } perfState_t;

endpackage

/* testbench/core_event_source.sv */
// Far-side model: core pipeline, caches and bus interface
`timescale 1ns/10ps
module core_event_source
    import perf_event_pkg::*;
(
    input wire logic [31:0] rnd,
    output coreEvt_t coreEvt
);
    // Halt is rarer than running, so unhalted counts see both states
    assign coreEvt = '{coreHalted: rnd[2:0] == 3'h0, otherHalted: rnd[3], busTick: rnd[4],
        dataRead: rnd[5], dataWrite: rnd[6], lineReadIssue: &rnd[8:7], lineReadDone: rnd[9]};
endmodule // core_event_source

/* testbench/tb_top.sv */
// Self-checking bench for the performance event counter
`timescale 1ns/10ps
module tb_top;
    import perf_event_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    evtSel_t evtSel = '0;
    logic anyThread = 1'b0;
    logic [31:0] rnd = 32'h0;
    coreEvt_t coreEvt;
    logic [CNT_W-1:0] progCount;
    logic [CNT_W-1:0] fixedCount;
    logic [PEND_W-1:0] pendReads;
    longint expProg = 0;
    longint expFixed = 0;
    int expPend = 0;
    int failures = 0;
    int totalChecks = 0;
    int seed = 86509;
    logic [15:0] sels [10] = '{16'h3c00, 16'h3c01, 16'h3c02, 16'h4021, 16'h4022, 16'h6000,
        16'h6055, 16'h3c03, 16'h4000, 16'h0000};

    always #2.5 clk = ~clk;

    core_event_source src_u (.rnd(rnd), .coreEvt(coreEvt));
    perf_event_counter dut_u (.clk(clk), .nrst(nrst), .evtSel(evtSel), .coreEvt(coreEvt),
        .anyThread(anyThread), .progCount(progCount), .fixedCount(fixedCount),
        .pendReads(pendReads));

    // Inputs only move on the falling edge, so the rising edge sees them settled
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            expProg = 0;
            expFixed = 0;
            expPend = 0;
        end
        else
        begin
            expFixed += !coreEvt.coreHalted;
            case ({evtSel.eventNum, evtSel.unitMask})
                16'h3c00: expProg += !coreEvt.coreHalted;
                16'h3c01: expProg += coreEvt.busTick && !coreEvt.coreHalted;
                16'h3c02: expProg += coreEvt.busTick && !coreEvt.coreHalted && coreEvt.otherHalted;
                16'h4021: expProg += coreEvt.dataRead;
                16'h4022: expProg += coreEvt.dataWrite;
                default:
                    if (evtSel.eventNum == EVT_BUS_OUTST)
                        expProg += expPend + coreEvt.lineReadIssue;
            endcase
            if (coreEvt.lineReadIssue && !coreEvt.lineReadDone && expPend < 15)
                expPend++;
            else if (coreEvt.lineReadDone && !coreEvt.lineReadIssue && expPend > 0)
                expPend--;
        end
    end

    task automatic cmp_count(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp);
        totalChecks++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_pend(input logic [PEND_W-1:0] got, input logic [PEND_W-1:0] exp);
        totalChecks++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test;
        if (failures == 0 && totalChecks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        for (int i = 0; i < 3000; i++)
        begin
            @(negedge clk);
            cmp_count(progCount, expProg[CNT_W-1:0]);
            cmp_count(fixedCount, expFixed[CNT_W-1:0]);
            cmp_pend(pendReads, expPend[PEND_W-1:0]);
            rnd = $random(seed);
            // Withholding completions drives the pending count into saturation
            if (i >= 2050 && i < 2150)
                rnd[9] = 1'b0;
            anyThread = rnd[31];
            // Every selector, unknown pairs included, held for 25 cycles
            evtSel = sels[(i / 25) % 10];
            nrst = (i != 1500);
        end
        end_of_test;
    end
endmodule // tb_top
